// >>> rtl/rtcal_regs.sv
// Calendar clock register block: time keeping, alarm, flags, supply status and RAM.
//
// The strobed register port is this design's own decision.
`include "rtcal_params.svh"
module rtcal_regs
    import rtcal_pkg::*;
#(
    parameter int TICK_CYCLES = `RTC_SECOND_NS / `RTC_CLK_PERIOD_NS,
    parameter int UIP_CYCLES = `RTC_UIP_WINDOW_NS / `RTC_CLK_PERIOD_NS
) (
    input wire logic clock,           // System clock, 100 MHz
    input wire logic reset,           // Synchronous reset, active high
    input wire logic [7:0] addr,      // Bit 7 bank, bits 6:0 index
    input wire logic [7:0] wr_data,   // Write data
    input wire logic wr_en,           // Write strobe
    input wire logic rd_en,           // Read strobe
    output logic [7:0] rd_data,       // Read data, the cycle after the strobe
    input wire logic battery_ok_pin,  // Supply above battery threshold, asynchronous
    output logic irq                  // Interrupt output, active high
);
    //--------------------------------------------------------------------------
    // State and decode
    //--------------------------------------------------------------------------
    rtcal_state_t q;
    rtcal_state_t next_q;

    logic ext_bank;
    logic [6:0] idx;
    logic [7:0] ram_rd;
    logic ram_we;
    logic [7:0] ram_addr;
    logic [7:0] t_sec;
    logic [7:0] t_min;
    logic [7:0] t_hour;
    logic [7:0] t_wday;
    logic [7:0] t_date;
    logic [7:0] t_month;
    logic [7:0] t_year;
    logic [7:0] t_century;
    logic alarm_hit;
    logic run;
    logic tick;
    logic per_event;
    logic uip;
    logic [3:0] rate_sel;

    // Mask of low divider bits for a periodic rate
    function automatic logic [15:0] rate_mask(input logic [3:0] r);
        return 16'((17'h1 << r) - 17'h1);
    endfunction

    // Register-or-RAM decode of the standard bank
    function automatic logic is_reg(input logic [6:0] i);
        return (i < `RTC_IDX_RAM_FIRST) || (i == `RTC_IDX_DATE_AL)
            || (i == `RTC_IDX_MON_AL) || (i == `RTC_IDX_CENTURY);
    endfunction

    assign ext_bank = addr[`RTC_ADDR_BANK_BIT];
    assign idx = addr[6:0];
    assign ram_addr = {ext_bank, idx};

    // Standard RAM skips registers and overlaid alarm bytes; extended bank is all RAM
    assign ram_we = wr_en && (ext_bank || !is_reg(idx));

    rtcal_ram #(
        .DEPTH(256)
    ) u_ram (
        .clock(clock),
        .wr_en(ram_we),
        .wr_addr(ram_addr),
        .wr_data(wr_data),
        .rd_addr(ram_addr),
        .rd_data(ram_rd)
    );

    rtcal_time u_time (
        .bin(q.mode_ctl[`RTC_MODE_BIN_BIT]),
        .h24(q.mode_ctl[`RTC_MODE_H24_BIT]),
        .sec(q.sec),
        .min(q.min),
        .hour(q.hour),
        .wday(q.wday),
        .date(q.date),
        .month(q.month),
        .year(q.year),
        .century(q.century),
        .sec_al(q.sec_al),
        .min_al(q.min_al),
        .hour_al(q.hour_al),
        .date_al(q.date_al),
        .mon_al(q.mon_al),
        .next_sec(t_sec),
        .next_min(t_min),
        .next_hour(t_hour),
        .next_wday(t_wday),
        .next_date(t_date),
        .next_month(t_month),
        .next_year(t_year),
        .next_century(t_century),
        .alarm_hit(alarm_hit)
    );

    //--------------------------------------------------------------------------
    // Dividers and events
    //--------------------------------------------------------------------------
    // Time runs only with the divider enabled and set mode off
    assign run = (q.rate_ctl[6:4] == `RTC_DIV_RUN) && !q.mode_ctl[`RTC_MODE_SET_BIT];
    assign tick = run && (q.tick_cnt == 32'(TICK_CYCLES - 1));
    assign rate_sel = q.rate_ctl[3:0];
    assign per_event = run && (rate_sel != 4'h0)
        && ((q.per_cnt & rate_mask(rate_sel)) == 16'h0000);
    assign uip = run && (q.tick_cnt >= 32'(TICK_CYCLES - UIP_CYCLES));

    //--------------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------------
    always_comb begin
        next_q = q;
        // Two-stage synchroniser on the supply comparator pin
        next_q.sync_a = battery_ok_pin;
        next_q.sync_b = q.sync_a;

        // Second prescaler and periodic divider
        next_q.tick_cnt = (!run || tick) ? 32'h0 : q.tick_cnt + 32'h1;
        next_q.per_cnt = run ? q.per_cnt + 16'h1 : 16'h0;

        // Read of the flag register clears flags; new events below win
        if (rd_en && !ext_bank && idx == `RTC_IDX_FLAGS) begin
            next_q.uf = 1'b0;
            next_q.af = 1'b0;
            next_q.pf = 1'b0;
        end

        // Once-a-second update of the calendar
        if (tick) begin
            next_q.sec = t_sec;
            next_q.min = t_min;
            next_q.hour = t_hour;
            next_q.wday = t_wday;
            next_q.date = t_date;
            next_q.month = t_month;
            next_q.year = t_year;
            next_q.century = t_century;
            next_q.uf = 1'b1;
            if (alarm_hit) begin
                next_q.af = 1'b1;
            end
        end
        if (per_event) begin
            next_q.pf = 1'b1;
        end

        // Supply flag drops at once and is refreshed by a read
        if (rd_en && !ext_bank && idx == `RTC_IDX_SUPPLY) begin
            next_q.valid = q.sync_b;
        end else begin
            next_q.valid = q.valid && q.sync_b;
        end
        if (!q.valid) begin
            next_q.af = 1'b0;
        end

        // Software writes; a write overrides the update of the same field
        if (wr_en && !ext_bank) begin
            case (idx)
                `RTC_IDX_SEC: next_q.sec = wr_data;
                `RTC_IDX_SEC_AL: next_q.sec_al = wr_data;
                `RTC_IDX_MIN: next_q.min = wr_data;
                `RTC_IDX_MIN_AL: next_q.min_al = wr_data;
                `RTC_IDX_HOUR: next_q.hour = wr_data;
                `RTC_IDX_HOUR_AL: next_q.hour_al = wr_data;
                `RTC_IDX_WDAY: next_q.wday = wr_data;
                `RTC_IDX_DATE: next_q.date = wr_data;
                `RTC_IDX_MONTH: next_q.month = wr_data;
                `RTC_IDX_YEAR: next_q.year = wr_data;
                `RTC_IDX_RATE: next_q.rate_ctl = {1'b0, wr_data[6:0]};
                `RTC_IDX_MODE: next_q.mode_ctl = wr_data & `RTC_MODE_RW_MASK;
                `RTC_IDX_DATE_AL: next_q.date_al = wr_data;
                `RTC_IDX_MON_AL: next_q.mon_al = wr_data;
                `RTC_IDX_CENTURY: next_q.century = wr_data;
                default: ;
            endcase
        end

        // Interrupt line follows enabled flags
        next_q.irq = (next_q.uf && q.mode_ctl[`RTC_MODE_UIE_BIT])
            || (next_q.af && q.mode_ctl[`RTC_MODE_AIE_BIT])
            || (next_q.pf && q.mode_ctl[`RTC_MODE_PIE_BIT]);

        // Registered read answer, zero outside a read
        next_q.rd_data = 8'h00;
        if (rd_en) begin
            if (ext_bank) begin
                next_q.rd_data = ram_rd;
            end else begin
                case (idx)
                    `RTC_IDX_SEC: next_q.rd_data = q.sec;
                    `RTC_IDX_SEC_AL: next_q.rd_data = q.sec_al;
                    `RTC_IDX_MIN: next_q.rd_data = q.min;
                    `RTC_IDX_MIN_AL: next_q.rd_data = q.min_al;
                    `RTC_IDX_HOUR: next_q.rd_data = q.hour;
                    `RTC_IDX_HOUR_AL: next_q.rd_data = q.hour_al;
                    `RTC_IDX_WDAY: next_q.rd_data = q.wday;
                    `RTC_IDX_DATE: next_q.rd_data = q.date;
                    `RTC_IDX_MONTH: next_q.rd_data = q.month;
                    `RTC_IDX_YEAR: next_q.rd_data = q.year;
                    `RTC_IDX_RATE: next_q.rd_data = {uip, q.rate_ctl[6:0]};
                    `RTC_IDX_MODE: next_q.rd_data = q.mode_ctl;
                    `RTC_IDX_FLAGS: next_q.rd_data = {q.irq, q.pf, q.af, q.uf, 4'h0};
                    `RTC_IDX_SUPPLY: next_q.rd_data = {q.valid, 7'h00};
                    `RTC_IDX_DATE_AL: next_q.rd_data = q.date_al;
                    `RTC_IDX_MON_AL: next_q.rd_data = q.mon_al;
                    `RTC_IDX_CENTURY: next_q.rd_data = q.century;
                    default: next_q.rd_data = ram_rd;
                endcase
            end
        end
    end

    //--------------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            q <= '0;
            q.sec_al <= `RTC_RST_ALARM;
            q.min_al <= `RTC_RST_ALARM;
            q.hour_al <= `RTC_RST_ALARM;
            q.date_al <= `RTC_RST_ALARM;
            q.mon_al <= `RTC_RST_ALARM;
            q.century <= `RTC_RST_CENTURY;
            q.wday <= `RTC_RST_DATE;
            q.date <= `RTC_RST_DATE;
            q.month <= `RTC_RST_DATE;
            q.rate_ctl <= `RTC_RST_RATE;
            q.mode_ctl <= `RTC_RST_MODE;
        end else begin
            q <= next_q;
        end
    end

    assign rd_data = q.rd_data;
    assign irq = q.irq;
endmodule

// >>> rtl/rtcal_params.svh
// Constants of the calendar clock register block: offsets, fields, resets, timing.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef RTCAL_PARAMS_SVH
`define RTCAL_PARAMS_SVH

// Register indices
`define RTC_IDX_SEC 7'h00
`define RTC_IDX_SEC_AL 7'h01
`define RTC_IDX_MIN 7'h02
`define RTC_IDX_MIN_AL 7'h03
`define RTC_IDX_HOUR 7'h04
`define RTC_IDX_HOUR_AL 7'h05
`define RTC_IDX_WDAY 7'h06
`define RTC_IDX_DATE 7'h07
`define RTC_IDX_MONTH 7'h08
`define RTC_IDX_YEAR 7'h09
`define RTC_IDX_RATE 7'h0a
`define RTC_IDX_MODE 7'h0b
`define RTC_IDX_FLAGS 7'h0c
`define RTC_IDX_SUPPLY 7'h0d
`define RTC_IDX_DATE_AL 7'h7d
`define RTC_IDX_MON_AL 7'h7e
`define RTC_IDX_CENTURY 7'h7f
`define RTC_IDX_RAM_FIRST 7'h0e
`define RTC_ADDR_BANK_BIT 7

// Field positions
`define RTC_RATE_UIP_BIT 7
`define RTC_DIV_RUN 3'h2
`define RTC_MODE_SET_BIT 7
`define RTC_MODE_PIE_BIT 6
`define RTC_MODE_AIE_BIT 5
`define RTC_MODE_UIE_BIT 4
`define RTC_MODE_BIN_BIT 2
`define RTC_MODE_H24_BIT 1
`define RTC_MODE_RW_MASK 8'hf7
`define RTC_DONT_CARE 2'h3

// Reset values
`define RTC_RST_ALARM 8'hc0
`define RTC_RST_CENTURY 8'h00
`define RTC_RST_DATE 8'h01
`define RTC_RST_RATE 8'h20
`define RTC_RST_MODE 8'h02

// Timing
`define RTC_CLK_PERIOD_NS 10
`define RTC_SECOND_NS 1000000000
`define RTC_UIP_WINDOW_NS 2000

`endif

// >>> rtl/rtcal_pkg.sv
// Types shared by the calendar clock register block.
package rtcal_pkg;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] sec_al;
        logic [7:0] min;
        logic [7:0] min_al;
        logic [7:0] hour;
        logic [7:0] hour_al;
        logic [7:0] wday;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] rate_ctl;
        logic [7:0] mode_ctl;
        logic [7:0] date_al;
        logic [7:0] mon_al;
        logic [7:0] century;
        logic uf;
        logic af;
        logic pf;
        logic irq;
        logic valid;
        logic sync_a;
        logic sync_b;
        logic [31:0] tick_cnt;
        logic [15:0] per_cnt;
        logic [7:0] rd_data;
    } rtcal_state_t;

endpackage

// >>> rtl/rtcal_ram.sv
// Battery-backed general-purpose RAM of both banks.
module rtcal_ram #(
    parameter int DEPTH = 256
) (
    input wire logic clock,                  // System clock
    input wire logic wr_en,                  // Write one byte
    input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Linear write index
    input wire logic [7:0] wr_data,          // Byte to store
    input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Linear read index
    output logic [7:0] rd_data               // Byte at read index
);
    import rtcal_pkg::*;

    // Contents survive system reset, as a backed store would
    logic [7:0] mem [DEPTH];

    // Byte write
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read is combinational; the top registers the answer
    assign rd_data = mem[rd_addr];
endmodule

// >>> rtl/rtcal_time.sv
// Next-second arithmetic of the calendar and the alarm compare.
`include "rtcal_params.svh"
module rtcal_time
    import rtcal_pkg::*;
(
    input wire logic bin,             // Binary coding when high, BCD when low
    input wire logic h24,             // Twenty-four-hour mode when high
    input wire logic [7:0] sec,       // Present seconds
    input wire logic [7:0] min,       // Present minutes
    input wire logic [7:0] hour,      // Present hours
    input wire logic [7:0] wday,      // Present weekday
    input wire logic [7:0] date,      // Present date
    input wire logic [7:0] month,     // Present month
    input wire logic [7:0] year,      // Present year
    input wire logic [7:0] century,   // Present century
    input wire logic [7:0] sec_al,    // Seconds alarm
    input wire logic [7:0] min_al,    // Minutes alarm
    input wire logic [7:0] hour_al,   // Hours alarm
    input wire logic [7:0] date_al,   // Date alarm
    input wire logic [7:0] mon_al,    // Month alarm
    output logic [7:0] next_sec,      // Seconds one second on
    output logic [7:0] next_min,      // Minutes one second on
    output logic [7:0] next_hour,     // Hours one second on
    output logic [7:0] next_wday,     // Weekday one second on
    output logic [7:0] next_date,     // Date one second on
    output logic [7:0] next_month,    // Month one second on
    output logic [7:0] next_year,     // Year one second on
    output logic [7:0] next_century,  // Century one second on
    output logic alarm_hit            // Advanced time matches every alarm field
);
    // Coded byte to plain number
    function automatic logic [7:0] to_num(input logic [7:0] v, input logic b);
        return b ? v : 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
    endfunction

    // Plain number to coded byte
    function automatic logic [7:0] from_num(input logic [7:0] n, input logic b);
        logic [7:0] q;
        q = n / 8'd10;
        return b ? n : {q[3:0], 4'(n - 8'(q * 8'd10))};
    endfunction

    // Step with wrap from hi back to lo
    function automatic logic [7:0] step(input logic [7:0] v, input logic b,
                                        input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] n;
        n = to_num(v, b);
        return from_num((n >= hi) ? lo : 8'(n + 8'd1), b);
    endfunction

    // Field match, with the don't-care code matching always
    function automatic logic field_match(input logic [7:0] al, input logic [7:0] cur);
        return (al[7:6] == `RTC_DONT_CARE) || (al == cur);
    endfunction

    logic [7:0] hnum;
    logic [7:0] h12;
    logic [7:0] hinc;
    logic [7:0] last_day;
    logic [7:0] ynum;
    logic sec_wrap;
    logic min_wrap;
    logic day_wrap;
    logic date_wrap;
    logic month_wrap;
    logic year_wrap;

    // Carry chain through the calendar
    always_comb begin
        hnum = to_num({1'b0, hour[6:0]}, bin);
        h12 = from_num(8'd12, bin);
        hinc = from_num((hnum >= 8'd12) ? 8'd1 : 8'(hnum + 8'd1), bin);
        ynum = to_num(year, bin);
        sec_wrap = (to_num(sec, bin) >= 8'd59);
        min_wrap = sec_wrap && (to_num(min, bin) >= 8'd59);
        next_sec = step(sec, bin, 8'd0, 8'd59);
        next_min = sec_wrap ? step(min, bin, 8'd0, 8'd59) : min;
        next_hour = hour;
        day_wrap = 1'b0;
        if (min_wrap) begin
            if (h24) begin
                next_hour = step(hour, bin, 8'd0, 8'd23);
                day_wrap = (hnum >= 8'd23);
            end else if (hnum == 8'd11) begin
                next_hour = {~hour[7], h12[6:0]};
                day_wrap = hour[7];
            end else begin
                next_hour = {hour[7], hinc[6:0]};
            end
        end
        case (to_num(month, bin))
            8'd2: last_day = (ynum[1:0] == 2'h0) ? 8'd29 : 8'd28;
            8'd4, 8'd6, 8'd9, 8'd11: last_day = 8'd30;
            default: last_day = 8'd31;
        endcase
        date_wrap = day_wrap && (to_num(date, bin) >= last_day);
        month_wrap = date_wrap && (to_num(month, bin) >= 8'd12);
        year_wrap = month_wrap && (ynum >= 8'd99);
        next_wday = day_wrap ? step(wday, bin, 8'd1, 8'd7) : wday;
        next_date = day_wrap ? step(date, bin, 8'd1, last_day) : date;
        next_month = date_wrap ? step(month, bin, 8'd1, 8'd12) : month;
        next_year = month_wrap ? step(year, bin, 8'd0, 8'd99) : year;
        next_century = year_wrap ? step(century, bin, 8'd0, 8'd99) : century;
        alarm_hit = field_match(sec_al, next_sec) && field_match(min_al, next_min)
            && field_match(hour_al, next_hour) && field_match(date_al, next_date)
            && field_match(mon_al, next_month);
    end
endmodule

// >>> tb/rtcal_regs_props.sv
// Port-level assertions of the calendar clock register block.
module rtcal_regs_props #(
    parameter int TICK_CYCLES = 20,
    parameter int UIP_CYCLES = 2
) (
    input wire logic clock,           // System clock
    input wire logic reset,           // Synchronous reset
    input wire logic [7:0] addr,      // Register index
    input wire logic [7:0] wr_data,   // Write data
    input wire logic wr_en,           // Write strobe
    input wire logic rd_en,           // Read strobe
    input wire logic [7:0] rd_data,   // Read data
    input wire logic battery_ok_pin,  // Supply status pin
    input wire logic irq              // Interrupt output
);
    logic cen_wr;
    logic mon_wr;

    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    // Note whether century or month alarm was written since reset
    always_ff @(posedge clock) begin
        cen_wr <= !reset && (cen_wr || (wr_en && addr == 8'h7f));
        mon_wr <= !reset && (mon_wr || (wr_en && addr == 8'h7e));
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_rd(a);
        rd_en && addr == a;
    endsequence
    sequence s_wr(a);
        wr_en && addr == a;
    endsequence

    property p_rd_idle;
        !rd_en |=> rd_data == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

    property p_mon_rst;
        s_rd(8'h7e) ##0 !mon_wr |=> rd_data == 8'hc0;
    endproperty
    a_mon_rst: assert property (p_mon_rst) else $error("month alarm reset wrong");

    property p_cen_rst;
        s_rd(8'h7f) ##0 !cen_wr |=> rd_data == 8'h00;
    endproperty
    a_cen_rst: assert property (p_cen_rst) else $error("century reset wrong");

    property p_store;
        wr_en && addr >= 8'h0e ##2 rd_en && addr == $past(addr, 2)
            |=> rd_data == $past(wr_data, 3);
    endproperty
    a_store: assert property (p_store) else $error("stored byte lost");

    property p_mode_store;
        s_wr(8'h0b) ##2 s_rd(8'h0b) |=> rd_data == ($past(wr_data, 3) & 8'hf7);
    endproperty
    a_mode_store: assert property (p_mode_store) else $error("mode byte wrong");

    property p_irq_clear;
        s_rd(8'h0c) ##0 irq |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("flag read kept irq");

    property p_sup_low;
        !battery_ok_pin [*6] ##0 s_rd(8'h0d) |=> rd_data == 8'h00;
    endproperty
    a_sup_low: assert property (p_sup_low) else $error("supply bit high on low supply");

    property p_sup_refresh;
        battery_ok_pin [*4] ##0 s_rd(8'h0d) ##1 battery_ok_pin [*4] ##0 s_rd(8'h0d)
            |=> rd_data == 8'h80;
    endproperty
    a_sup_refresh: assert property (p_sup_refresh) else $error("supply bit not refreshed");
endmodule

// >>> tb/test_rtc_calendar_alarm_regs.sv
// Self-checking bench of the calendar clock register block.
module test_rtc_calendar_alarm_regs
    import rtcal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 20;
    logic clock, reset, wr_en, rd_en, battery_ok_pin, irq;
    logic [7:0] addr, wr_data, rd_data;
    int err_count, total_checks;

    rtcal_regs #(.TICK_CYCLES(TICK), .UIP_CYCLES(2)) dut_u (.clock(clock), .reset(reset),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .battery_ok_pin(battery_ok_pin), .irq(irq));

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Strobe for one edge, then one quiet edge; tasks start and end on an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        @(posedge clock);
    endtask

    // Read data is taken at the edge that ends the cycle in which it stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
        check(rd_data, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Wait for irq under a bound, then compare its level
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3 * TICK) begin
            @(posedge clock);
            n++;
        end
        check({7'h00, irq}, 8'h01);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up;
        logic [7:0] ra[8] = '{8'h0d, 8'h7e, 8'h7f, 8'h7d, 8'h0c, 8'h0b, 8'h06, 8'h08};
        logic [7:0] rv[8] = '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h00, 8'h02, 8'h01, 8'h01};
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], rv[i]);
        end
        $display("power-up values done");
    endtask

    task automatic t_store;
        logic [7:0] wa[6] = '{8'h0e, 8'h7c, 8'h80, 8'hff, 8'h7e, 8'h7f};
        logic [7:0] wd[6] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h0c, 8'h63};
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 6; i++) begin
            wr(wa[i], wd[i]);
            rd(wa[i], wd[i]);
            sum = sum + wd[i];
        end
        wr(8'h7b, sum);
        rd(8'h7b, sum);
        wr(8'h0d, 8'hff);
        rd(8'h0d, 8'h00);
        $display("store and banks done");
    endtask

    // Freeze, load a rollover point, run one second on and compare
    task automatic t_roll(input logic [7:0] mode, h, ms, wd, dt, mo, eh, ewd, emo);
        wr(8'h0b, 8'h80 | mode);
        wr(8'h04, h);
        wr(8'h02, ms);
        wr(8'h00, ms);
        wr(8'h06, wd);
        wr(8'h07, dt);
        wr(8'h08, mo);
        wr(8'h0b, mode);
        rd(8'h0b, mode);
        idle(TICK + 2);
        rd(8'h04, eh);
        rd(8'h06, ewd);
        rd(8'h08, emo);
        $display("rollover mode %h done", mode);
    endtask

    task automatic t_irq;
        wr(8'h0b, 8'h12);
        wait_irq();
        rd(8'h0c, 8'h90);
        check({7'h00, irq}, 8'h00);
        rd(8'h0c, 8'h00);
        wr(8'h0b, 8'h02);
        // Periodic flag every eight cycles, interrupt through its enable only
        wr(8'h0a, 8'h23);
        wr(8'h0b, 8'h42);
        wait_irq();
        rd(8'h0c, 8'hd0);
        wr(8'h0a, 8'h20);
        wr(8'h0b, 8'h02);
        $display("update and periodic flags done");
    endtask

    task automatic t_alarm;
        battery_ok_pin <= 1'b1;
        idle(5);
        rd(8'h0d, 8'h00);
        idle(2);
        rd(8'h0d, 8'h80);
        wr(8'h0b, 8'h22);
        idle(2 * TICK + 5);
        check({7'h00, irq}, 8'h00);
        rd(8'h0c, 8'h10);
        wr(8'h7e, 8'hc0);
        wait_irq();
        rd(8'h0c, 8'hb0);
        wr(8'h0b, 8'h02);
        $display("alarm match done");
    endtask

    task automatic t_supply_low;
        battery_ok_pin <= 1'b0;
        idle(8);
        rd(8'h0d, 8'h00);
        $display("supply loss done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Cut a hang short well past the expected run time
    initial begin
        #50000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        reset = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        battery_ok_pin = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        t_power_up();
        t_store();
        t_roll(8'h02, 8'h23, 8'h59, 8'h07, 8'h31, 8'h12, 8'h00, 8'h01, 8'h01);
        t_roll(8'h06, 8'h17, 8'h3b, 8'h07, 8'h1f, 8'h0c, 8'h00, 8'h01, 8'h01);
        t_roll(8'h00, 8'h11, 8'h59, 8'h03, 8'h31, 8'h12, 8'h92, 8'h03, 8'h12);
        t_roll(8'h04, 8'h8b, 8'h3b, 8'h07, 8'h1f, 8'h0c, 8'h0c, 8'h01, 8'h01);
        t_irq();
        t_alarm();
        t_supply_low();
        tally_and_finish();
    end
endmodule

bind rtcal_regs rtcal_regs_props #(.TICK_CYCLES(TICK_CYCLES), .UIP_CYCLES(UIP_CYCLES)) chk_u (
    .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .battery_ok_pin(battery_ok_pin), .irq(irq));
